// ---- rtl/veil_defines.vh ----
`ifndef VEIL_DEFINES_VH
`define VEIL_DEFINES_VH
// Vector table (program word addresses)
`define VEIL_VEC_RESET      14'h0000
`define VEIL_VEC_EXT        14'h0002
`define VEIL_VEC_STEP       14'h0002
`define VEIL_VEC_LAST       14'h0036
`define VEIL_NUM_VECTORS    28
`define VEIL_NUM_SOURCES    27
`define VEIL_SRC_EXT        0
`define VEIL_SRC_PCG0       1
`define VEIL_SRC_PCG1       2
`define VEIL_SRC_PCG2       3
// Pin-change group bit ranges
`define VEIL_PC_WIDTH       18
`define VEIL_G0_HI          7
`define VEIL_G0_LO          0
`define VEIL_G1_HI          11
`define VEIL_G1_LO          8
`define VEIL_G2_HI          17
`define VEIL_G2_LO          12
// External sense encodings
`define VEIL_SENSE_LOW      2'h0
`define VEIL_SENSE_ANY      2'h1
`define VEIL_SENSE_FALL     2'h2
`define VEIL_SENSE_RISE     2'h3
// Start-up counter
`define VEIL_SUT_WIDTH      16
`define VEIL_SUT_BASE       16'h0010
`endif

// ---- rtl/veil_sync.v ----
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module veil_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             i_clock,
  input  wire             i_srst,
  // Asynchronous input and settled output
  input  wire [WIDTH-1:0] i_async,
  input  wire [WIDTH-1:0] i_reset_value,
  output reg  [WIDTH-1:0] o_level
);
  reg [WIDTH-1:0] stage_one;   // Metastability catcher, read only by stage_two
  reg [WIDTH-1:0] stage_two;   // Second stage
  reg [WIDTH-1:0] stage_three; // Third stage

  // Shift chain and agreement filter
  always @(posedge i_clock) begin
    if (i_srst) begin
      stage_one   <= i_reset_value;
      stage_two   <= i_reset_value;
      stage_three <= i_reset_value;
      o_level     <= i_reset_value;
    end else begin
      stage_one   <= i_async;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      o_level     <= (stage_two & stage_three) | (o_level & (stage_two ^ stage_three));
    end
  end
endmodule // veil_sync
`default_nettype wire

// ---- rtl/veil_irq.v ----
`timescale 1ns/1ns
`default_nettype none
`include "veil_defines.vh"
// How it works
// - Reset vector sits at address zero
// - 28 vectors, two words apart, last 0x0036
// - External pin request vectors to 0x0002
// - Pin-change groups vector to 0x0004..0x0008
// - Timer requests occupy 0x000C through 0x0018
// - Serial ports use 0x001E through 0x002C
// - Only enabled sources cause vector fetch
// - Pins trigger even when driven as outputs
// - Group zero: any enabled bit 7:0 toggles
// - Group one: any enabled bit 11:8 toggles
// - Group two: any enabled bit 17:12 toggles
// - Per-group masks select contributing pins
// - Pin changes wake from every sleep mode
// - External pin: falling, rising or low level
// - Level mode requests while pin stays low
// - Edge detection needs the running clock
// - Low level wake is also sampled on the clock
// - Level gone before start-up: wake, no request
// - Then resume after the sleep instruction
// - Start-up time taken from fuse settings
// - Sense code: low, any, falling, rising
// - Pin sampled first; long pulses always caught
// - Flags clear on handler entry or write-one
// - Pin needs mask bit and group enable
module veil_irq (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_srst,
  // Pins, sampled at the pad whatever their direction
  input  wire        i_ext_irq_pin,
  input  wire [17:0] i_pin_change_input,
  // Configuration
  input  wire [1:0]  i_ext_sense_select,
  input  wire        i_ext_enable,
  input  wire [2:0]  i_group_enable,
  input  wire [7:0]  i_pin_change_mask_zero,
  input  wire [3:0]  i_pin_change_mask_one,
  input  wire [5:0]  i_pin_change_mask_two,
  input  wire [1:0]  i_startup_time_fuse,
  input  wire [3:0]  i_clock_source_fuse,
  // Flag write-one clears: bit0 ext, bits 1..3 groups 0..2
  input  wire [3:0]  i_flag_clear,
  // Other peripheral requests, vectors 6..28 (already gated by their enables)
  input  wire [22:0] i_periph_irq,
  // Core handshake
  input  wire        i_global_enable,
  input  wire        i_irq_ack,
  input  wire        i_sleeping,
  output wire        o_irq_req,
  output reg  [13:0] o_vector_addr,
  output reg  [4:0]  o_vector_num,
  output wire [3:0]  o_flags,
  output reg         o_wake,
  output reg         o_startup_busy
);
  // Returns vector address for a 1-based vector number
  function [13:0] vec_addr;
    input [4:0] num;
    begin
      vec_addr = `VEIL_VEC_RESET + ((num - 5'h01) * `VEIL_VEC_STEP);
    end
  endfunction

  // Synchronised pins; asynchronous paths cross here
  wire [17:0] pc_level;   // Settled pin-change levels
  wire        ext_level;  // Settled external pin level
  veil_sync #(.WIDTH(19)) u_sync (
    .i_clock       (i_clock),
    .i_srst        (i_srst),
    .i_async       ({i_ext_irq_pin, i_pin_change_input}),
    .i_reset_value (19'h7ffff),
    .o_level       ({ext_level, pc_level})
  );

  reg [17:0] pc_prev;     // Previous settled pin-change levels
  reg        ext_prev;    // Previous settled external level
  reg [3:0]  flag;        // Sticky flags: ext, group0..2
  reg [`VEIL_SUT_WIDTH-1:0] sut_count; // Wake start-up countdown
  reg        sleep_prev;  // Sleep state one cycle ago

  // Per-pin toggle and mask
  wire [17:0] pc_toggle = pc_level ^ pc_prev;
  wire [17:0] pc_mask = {i_pin_change_mask_two, i_pin_change_mask_one, i_pin_change_mask_zero};
  wire [17:0] pc_hit = pc_toggle & pc_mask;

  // Group hits gated by group enables
  wire grp0_hit = |pc_hit[`VEIL_G0_HI:`VEIL_G0_LO] & i_group_enable[0];
  wire grp1_hit = |pc_hit[`VEIL_G1_HI:`VEIL_G1_LO] & i_group_enable[1];
  wire grp2_hit = |pc_hit[`VEIL_G2_HI:`VEIL_G2_LO] & i_group_enable[2];

  // External edge detection on sampled pin
  reg ext_edge;
  always @* begin
    case (i_ext_sense_select)
      `VEIL_SENSE_ANY:  ext_edge = ext_level ^ ext_prev;
      `VEIL_SENSE_FALL: ext_edge = ext_prev & ~ext_level;
      `VEIL_SENSE_RISE: ext_edge = ~ext_prev & ext_level;
      default:          ext_edge = 1'b0;
    endcase
  end

  // Level mode: request tracks the pin, only after start-up completed
  wire level_mode = (i_ext_sense_select == `VEIL_SENSE_LOW);
  wire level_req  = level_mode & ~ext_level & ~o_startup_busy;

  // Start-up time from fuses
  wire [`VEIL_SUT_WIDTH-1:0] sut_load =
    `VEIL_SUT_BASE << ({1'b0, i_startup_time_fuse} + {1'b0, i_clock_source_fuse[1:0]});

  // Pending sources, vector 2 onward
  wire [`VEIL_NUM_SOURCES-1:0] pending;
  assign pending = {i_periph_irq,
                    flag[3] & i_group_enable[2],
                    flag[2] & i_group_enable[1],
                    flag[1] & i_group_enable[0],
                    i_ext_enable & (level_mode ? level_req : flag[0])};

  // Lowest-numbered pending source
  reg [4:0] win_idx;
  reg       win_any;
  integer k;
  always @* begin
    win_idx = 5'h00;
    win_any = 1'b0;
    for (k = `VEIL_NUM_SOURCES - 1; k >= 0; k = k - 1) begin
      if (pending[k]) begin
        win_idx = k[4:0];
        win_any = 1'b1;
      end
    end
  end

  assign o_irq_req = win_any & i_global_enable & ~o_startup_busy;
  assign o_flags   = flag;

  // Flag, history and vector registers
  always @(posedge i_clock) begin
    if (i_srst) begin
      pc_prev       <= 18'h3ffff;
      ext_prev      <= 1'b1;
      flag          <= 4'h0;
      o_vector_addr <= `VEIL_VEC_RESET;
      o_vector_num  <= 5'h01;
    end else begin
      pc_prev  <= pc_level;
      ext_prev <= ext_level;
      // Set wins over clear; ack clears the winning flag
      flag[0] <= ~level_mode & (ext_edge |
                 (flag[0] & ~i_flag_clear[0] &
                  ~(i_irq_ack & win_idx == 5'h00)));
      flag[1] <= grp0_hit | (flag[1] & ~i_flag_clear[1] &
                 ~(i_irq_ack & win_idx == 5'h01));
      flag[2] <= grp1_hit | (flag[2] & ~i_flag_clear[2] &
                 ~(i_irq_ack & win_idx == 5'h02));
      flag[3] <= grp2_hit | (flag[3] & ~i_flag_clear[3] &
                 ~(i_irq_ack & win_idx == 5'h03));
      // Register the vector the core would fetch
      o_vector_num  <= win_idx + 5'h02;
      o_vector_addr <= vec_addr(win_idx + 5'h02);
    end
  end

  // Wake detection and start-up countdown
  always @(posedge i_clock) begin
    if (i_srst) begin
      sut_count      <= {`VEIL_SUT_WIDTH{1'b0}};
      o_startup_busy <= 1'b0;
      o_wake         <= 1'b0;
      sleep_prev     <= 1'b0;
    end else begin
      sleep_prev <= i_sleeping;
      // Wake on any enabled pin change or low level while asleep
      o_wake <= i_sleeping & ((grp0_hit | grp1_hit | grp2_hit) |
                (i_ext_enable & level_mode & ~ext_level));
      if (i_sleeping & ~sleep_prev) begin
        sut_count      <= sut_load;
        o_startup_busy <= 1'b1;
      end else if (o_startup_busy & ~i_sleeping) begin
        if (sut_count == {`VEIL_SUT_WIDTH{1'b0}}) begin
          o_startup_busy <= 1'b0;
        end else begin
          sut_count <= sut_count - 1'b1;
        end
      end
    end
  end
endmodule // veil_irq
`default_nettype wire

// ---- verification/veil_irq_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// Port-level checker for the interrupt block
module veil_irq_chk (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic [1:0]  i_ext_sense_select,
  input wire logic [2:0]  i_group_enable,
  input wire logic [7:0]  i_pin_change_mask_zero,
  input wire logic        i_global_enable,
  input wire logic        o_irq_req,
  input wire logic [13:0] o_vector_addr,
  input wire logic [4:0]  o_vector_num,
  input wire logic [3:0]  o_flags,
  input wire logic        o_startup_busy
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // Group zero disabled with its flag clear
  sequence quiet_g0;
    !i_group_enable[0] && !o_flags[1];
  endsequence
  flags_reset_a: assert property (disable iff (1'b0) i_srst |=> o_flags == 4'h0)
    else $error("flags not cleared by reset");
  level_flag_a: assert property (i_ext_sense_select == 2'h0 && $past(i_ext_sense_select) == 2'h0 |-> !o_flags[0])
    else $error("external flag set in level mode");
  group_off_a: assert property (quiet_g0 |=> !o_flags[1])
    else $error("disabled group raised its flag");
  mask_off_a: assert property (i_pin_change_mask_zero == 8'h00 && !o_flags[1] |=> !o_flags[1])
    else $error("masked pins raised group zero");
  vec_map_a: assert property (o_vector_addr == {8'h00, o_vector_num - 5'd1, 1'b0})
    else $error("vector address not two words per number");
  vec_range_a: assert property (o_vector_num >= 5'd1 && o_vector_num <= 5'd28)
    else $error("vector number out of range");
  gie_off_a: assert property (!i_global_enable |-> !o_irq_req)
    else $error("request while globally disabled");
  busy_block_a: assert property (o_startup_busy |-> !o_irq_req)
    else $error("request during start-up");
endmodule // veil_irq_chk
bind veil_irq veil_irq_chk u_chk (.i_clock, .i_srst, .i_ext_sense_select, .i_group_enable,
  .i_pin_change_mask_zero, .i_global_enable, .o_irq_req, .o_vector_addr, .o_vector_num, .o_flags, .o_startup_busy);
`default_nettype wire

// ---- verification/veil_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Core side: takes a pending request after a chosen delay
module veil_core_model (
  input wire logic       i_clock,
  input wire logic       i_enable,  // Core accepts interrupts
  input wire logic [2:0] i_delay,   // Cycles to wait, at least one
  input wire logic       i_req,
  input wire logic [4:0] i_num,
  output logic           o_ack,     // One-cycle acknowledge
  output logic [4:0]     o_taken,   // Last vector taken
  output int             o_count    // Interrupts taken so far
);
  logic [2:0] wait_cnt;
  initial begin
    o_ack = 1'b0;
    o_taken = 5'h00;
    o_count = 0;
    wait_cnt = 3'h0;
  end
  // Waits so the registered vector has settled before it is taken
  always @(negedge i_clock) begin
    o_ack <= 1'b0;
    if (!i_enable || !i_req || o_ack) wait_cnt <= 3'h0;
    else if (wait_cnt < i_delay) wait_cnt <= wait_cnt + 3'h1;
    else begin
      o_ack <= 1'b1;
      o_taken <= i_num;
      o_count <= o_count + 1;
    end
  end
endmodule // veil_core_model
`default_nettype wire

// ---- verification/veil_irq_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module veil_irq_bench;
  logic        i_clock, i_srst, ext_pin, ext_en, gie, core_en, ack, req, busy, slp, wake;
  logic [17:0] pins;
  logic [1:0]  sense;
  logic [2:0]  grp, dly;
  logic [3:0]  clr, flags;
  logic [7:0]  m0;
  logic [4:0]  num, taken;
  logic [13:0] addr;
  logic [22:0] periph;
  int          n_fail, total_checks, took, t0;
  int          hi[3] = '{7, 11, 17};  // Top pin of each group
  veil_irq dut (.i_clock, .i_srst, .i_ext_irq_pin(ext_pin), .i_pin_change_input(pins), .i_ext_sense_select(sense),
    .i_ext_enable(ext_en), .i_group_enable(grp), .i_pin_change_mask_zero(m0), .i_pin_change_mask_one(m0[3:0]),
    .i_pin_change_mask_two(m0[5:0]), .i_startup_time_fuse(2'h0), .i_clock_source_fuse(4'h0), .i_flag_clear(clr),
    .i_periph_irq(periph), .i_global_enable(gie), .i_irq_ack(ack), .i_sleeping(slp), .o_irq_req(req),
    .o_vector_addr(addr), .o_vector_num(num), .o_flags(flags), .o_wake(wake), .o_startup_busy(busy));
  veil_core_model core (.i_clock, .i_enable(core_en), .i_delay(dly), .i_req(req), .i_num(num), .o_ack(ack),
    .o_taken(taken), .o_count(took));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // Waits, bounded, for one more interrupt taken and compares its vector
  task automatic take(input logic [4:0] exp);
    int start;
    start = took;
    for (int i = 0; i < 30 && took == start; i++) cyc(1);
    chk(taken, exp);
    chk(took, start + 1);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #(100 * 3000);
    n_fail++;
    final_report;
  end
  initial begin
    {i_srst, ext_pin, ext_en, gie, core_en} = 5'b11011;
    {pins, sense, grp, dly, clr, m0, periph} = {18'h3ffff, 2'h2, 3'h0, 3'h1, 4'h0, 8'hff, 23'h0};
    n_fail = 0;
    total_checks = 0;
    slp = 1'b0;
    cyc(20);
    chk({flags, addr, num}, {4'h0, 14'h0000, 5'd1});
    i_srst = 1'b0;
    cyc(6);
    chk(flags, 4'h0);
    $display("reset done");
    // Each group on its own vector, prompt then slow core
    for (int g = 0; g < 3; g++) begin
      grp = 3'h1 << g;
      dly = g ? 3'h4 : 3'h1;
      pins[hi[g]] = ~pins[hi[g]];
      take(5'd3 + g);
    end
    $display("groups done");
    m0 = 8'hfe;
    grp = 3'h1;
    pins[0] = ~pins[0];
    cyc(10);
    chk(flags, 4'h0);
    m0 = 8'h00;
    pins[3] = ~pins[3];
    cyc(10);
    chk(flags, 4'h0);
    m0 = 8'hff;
    grp = 3'h0;
    pins[1] = ~pins[1];
    cyc(10);
    chk(flags, 4'h0);
    $display("masking done");
    // Wrong edge ignored, right edge taken; any-change takes both
    for (int s = 1; s < 4; s++) begin
      ext_en = 1'b0;
      sense = s;
      ext_pin = (s == 3);
      dly = 3'h1;
      cyc(8);
      // Setup edge may have set the flag while disabled; clear it
      clr = 4'h1;
      cyc(1);
      clr = 4'h0;
      ext_en = 1'b1;
      t0 = took;
      ext_pin = ~ext_pin;
      cyc(10);
      chk(took - t0, s == 1);
      ext_pin = ~ext_pin;
      take(5'd2);
    end
    $display("edges done");
    dly = 3'h1;
    sense = 2'h0;
    ext_pin = 1'b0;
    cyc(10);
    t0 = took;
    cyc(10);
    chk(took - t0 >= 2, 1);
    chk(flags[0], 1'b0);
    ext_pin = 1'b1;
    cyc(10);
    chk(req, 1'b0);
    ext_en = 1'b0;
    $display("level done");
    // Several pending: lowest number wins; write-one clear; global mask
    core_en = 1'b0;
    grp = 3'h1;
    pins[2] = ~pins[2];
    periph = 23'h000420;
    cyc(10);
    chk(num, 5'd3);
    clr = 4'h2;
    cyc(1);
    clr = 4'h0;
    cyc(2);
    chk(flags, 4'h0);
    chk(addr, 14'h0014);
    periph = 23'h000400;
    cyc(2);
    chk(addr, 14'h001e);
    gie = 1'b0;
    cyc(2);
    chk(req, 1'b0);
    periph = 23'h0;
    $display("priority done");
    // Level wake from sleep: early release wakes only, held level interrupts
    {gie, core_en, grp, ext_en} = {1'b1, 1'b1, 3'h0, 1'b1};
    t0 = took;
    slp = 1'b1;
    cyc(3);
    chk(busy, 1'b1);
    ext_pin = 1'b0;
    cyc(8);
    chk(wake, 1'b1);
    ext_pin = 1'b1;
    slp = 1'b0;
    cyc(30);
    chk({busy, wake}, 2'h0);
    chk(took - t0, 0);
    slp = 1'b1;
    cyc(3);
    ext_pin = 1'b0;
    cyc(8);
    slp = 1'b0;
    cyc(30);
    chk(took - t0 >= 1, 1);
    ext_pin = 1'b1;
    ext_en = 1'b0;
    cyc(10);
    $display("sleep done");
    final_report;
  end
endmodule // veil_irq_bench
`default_nettype wire
